/* logic/wwc_pkg.sv */
// Register map, field layout, reset values and state codes of the watchdog and wake-up block.
// Assumes one 200 MHz clock and an 8-bit register port with 2 address bits.
// Overview of operation
// - Wake on pin edge, interrupt or overflow
// - Halt sets power-down flag
// - Clear instruction clears power-down flag
// - Sleep overflow: timeout flag, PC/SP reset only
// - Per-pin enable for falling-edge wake
// - Pin wake resumes after halt
// - Disabled or stack-full interrupt: resume, stays pending
// - Enabled interrupt with free stack: service it
// - Request set before halt cannot wake
// - Count slow oscillator ticks near 32kHz
// - Select code picks 2^8 to 2^15
// - Key 10101 disables, 01010 enables
// - Bad key resets after fixed delay
// - Power-on key enabled, select 011
// - Key fault flag set, software clears only
// - Running timeout resets device, sets timeout flag
// - Key fault, clear or halt clears counter
// - Cause register bits 7..1 read zero
// - Halt clears counter, counts only if enabled
package wwc_pkg;
   // Clock and slow oscillator
   localparam int unsigned CLK_HZ              = 200_000_000;
   localparam int unsigned SLOW_OSC_HZ         = 32_000;
   localparam int unsigned SLOW_DIV_CYC        = CLK_HZ / SLOW_OSC_HZ;
   localparam int unsigned KEY_FAULT_DELAY_CYC = 64;

   // Register addresses
   localparam logic [1:0] ADDR_WDT_CTRL  = 2'h0;
   localparam logic [1:0] ADDR_RST_CAUSE = 2'h1;
   localparam logic [1:0] ADDR_PORT_WAKE = 2'h2;
   localparam logic [1:0] ADDR_STATUS    = 2'h3;

   // Watchdog control fields
   localparam int unsigned KEY_LSB = 3;
   localparam int unsigned KEY_MSB = 7;
   localparam int unsigned SEL_LSB = 0;
   localparam int unsigned SEL_MSB = 2;
   localparam logic [4:0]  KEY_DISABLE = 5'h15;
   localparam logic [4:0]  KEY_ENABLE  = 5'h0A;
   localparam logic [7:0]  WDT_CTRL_POR = 8'h53;
   localparam int unsigned SEL_BASE_EXP = 8;

   // Reset cause and status fields
   localparam int unsigned KEY_FLAG_BIT = 0;
   localparam int unsigned PWR_DOWN_BIT = 0;
   localparam int unsigned TIMEOUT_BIT  = 1;
   localparam logic [7:0]  PORT_WAKE_POR = 8'h00;

   // Wake cause codes
   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_PIN  = 2'h1;
   localparam logic [1:0] CAUSE_INT  = 2'h2;
   localparam logic [1:0] CAUSE_WDT  = 2'h3;

   typedef enum logic [1:0] {
      WWC_ST_RUN   = 2'b00,
      WWC_ST_SLEEP = 2'b01,
      WWC_ST_FAULT = 2'b10
   } wwc_state_type;
endpackage : wwc_pkg

/* logic/wwc_watchdog_wake.sv */
// Watchdog counter, keyed enable, reset cause flags and low-power wake-up control.
// Assumes the core gives one-cycle halt and clear strobes and keeps its own request flags.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module wwc_watchdog_wake #(
   parameter int unsigned PORT_A_WIDTH        = 8,
   parameter int unsigned INT_COUNT           = 8,
   parameter int unsigned SLOW_DIV_CYC        = wwc_pkg::SLOW_DIV_CYC,
   parameter int unsigned KEY_FAULT_DELAY_CYC = wwc_pkg::KEY_FAULT_DELAY_CYC
) (
   // Clock and reset
   input  wire logic                    CLOCK_IN,
   input  wire logic                    SYS_RST_IN,
   // Register port
   input  wire logic [1:0]              REG_ADDR_IN,
   input  wire logic [7:0]              REG_WDATA_IN,
   input  wire logic                    REG_WR_IN,
   input  wire logic                    REG_RD_IN,
   output logic      [7:0]              REG_RDATA_OUT,
   // Core instructions
   input  wire logic                    HALT_IN,
   input  wire logic                    WATCHDOG_CLEAR_INSTRUCTION_IN,
   // Wake sources
   input  wire logic [PORT_A_WIDTH-1:0] PORT_A_IN,
   input  wire logic [INT_COUNT-1:0]    INT_REQ_IN,
   input  wire logic [INT_COUNT-1:0]    INT_EN_IN,
   input  wire logic                    STACK_FULL_IN,
   // Core control
   output logic                         SLEEP_OUT,
   output logic                         WAKE_OUT,
   output logic      [1:0]              WAKE_CAUSE_OUT,
   output logic                         WAKE_SERVICE_OUT,
   output logic                         DEVICE_RESET_OUT,
   output logic                         PC_SP_RESET_OUT,
   // Status flags
   output logic                         POWER_DOWN_FLAG_OUT,
   output logic                         TIMEOUT_FLAG_OUT,
   output logic                         WDT_ENABLED_OUT
);
   localparam int unsigned DIV_W = $clog2(SLOW_DIV_CYC);
   localparam int unsigned FLT_W = $clog2(KEY_FAULT_DELAY_CYC + 1);

   if (PORT_A_WIDTH < 1 || PORT_A_WIDTH > 8) begin : g_bad_port
      $error("PORT_A_WIDTH must be 1 to 8");
   end
   if (INT_COUNT < 1 || SLOW_DIV_CYC < 3 || KEY_FAULT_DELAY_CYC < 1) begin : g_bad_count
      $error("INT_COUNT, SLOW_DIV_CYC or KEY_FAULT_DELAY_CYC out of range");
   end

   function automatic logic [15:0] wwc_limit(input logic [2:0] sel);
      wwc_limit = 16'h0001 << (4'(wwc_pkg::SEL_BASE_EXP) + 4'(sel));
   endfunction : wwc_limit

   // Slow oscillator tick divider
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] div_nxt;
   logic             tick;

   always_comb begin
      tick    = (div_r == DIV_W'(SLOW_DIV_CYC - 1));
      div_nxt = tick ? '0 : div_r + 1'b1;
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   // Main state
   wwc_pkg::wwc_state_type   st_r, st_nxt;
   logic [7:0]               wdog_ctrl_r, wdog_ctrl_nxt;
   logic [7:0]               pin_wake_en_r, pin_wake_en_nxt;
   logic                     key_flag_r, key_flag_nxt;
   logic                     pwr_down_r, pwr_down_nxt;
   logic                     to_r, to_nxt;
   logic [15:0]              cnt_r, cnt_nxt;
   logic [FLT_W-1:0]         flt_r, flt_nxt;
   logic [PORT_A_WIDTH-1:0]  pa_prev_r;
   logic [INT_COUNT-1:0]     blocked_r, blocked_nxt;
   logic [7:0]               rdata_r, rdata_nxt;
   logic                     wake_r, wake_nxt;
   logic [1:0]               cause_r, cause_nxt;
   logic                     svc_r, svc_nxt;
   logic                     devrst_r, devrst_nxt;
   logic                     pcsp_r, pcsp_nxt;

   logic [4:0]               key;
   logic                     key_ok;
   logic                     enabled;
   logic                     ovf;
   logic                     clear_cnt;
   logic [15:0]              cnt_inc;
   logic [PORT_A_WIDTH-1:0]  pin_fall;
   logic [INT_COUNT-1:0]     new_req;
   logic                     svc;

   always_comb begin
      st_nxt      = st_r;
      wdog_ctrl_nxt   = wdog_ctrl_r;
      pin_wake_en_nxt = pin_wake_en_r;
      key_flag_nxt    = key_flag_r;
      pwr_down_nxt    = pwr_down_r;
      to_nxt      = to_r;
      flt_nxt     = flt_r;
      blocked_nxt = blocked_r & INT_REQ_IN;
      wake_nxt    = 1'b0;
      cause_nxt   = cause_r;
      svc_nxt     = 1'b0;
      devrst_nxt  = 1'b0;
      pcsp_nxt    = 1'b0;
      clear_cnt   = 1'b0;

      key     = wdog_ctrl_r[wwc_pkg::KEY_MSB:wwc_pkg::KEY_LSB];
      enabled = (key == wwc_pkg::KEY_ENABLE);
      key_ok  = enabled || (key == wwc_pkg::KEY_DISABLE);
      cnt_inc = cnt_r + 16'h0001;
      // Overflow on the tick that brings the count to the limit
      ovf     = enabled && tick && (st_r != wwc_pkg::WWC_ST_FAULT)
                && (cnt_inc == wwc_limit(wdog_ctrl_r[wwc_pkg::SEL_MSB:wwc_pkg::SEL_LSB]));

      pin_fall = pa_prev_r & ~PORT_A_IN & pin_wake_en_r[PORT_A_WIDTH-1:0];
      // Requests already pending at halt stay masked until they drop
      new_req  = INT_REQ_IN & ~blocked_r;
      svc      = (|(new_req & INT_EN_IN)) && !STACK_FULL_IN;

      // Register writes
      if (REG_WR_IN) begin
         case (REG_ADDR_IN)
            wwc_pkg::ADDR_WDT_CTRL:  wdog_ctrl_nxt   = REG_WDATA_IN;
            wwc_pkg::ADDR_RST_CAUSE: key_flag_nxt    = key_flag_r
                                                       & REG_WDATA_IN[wwc_pkg::KEY_FLAG_BIT];
            wwc_pkg::ADDR_PORT_WAKE: pin_wake_en_nxt = REG_WDATA_IN;
            default:                 pin_wake_en_nxt = pin_wake_en_r;
         endcase
      end

      case (st_r)
         wwc_pkg::WWC_ST_RUN: begin
            if (!key_ok) begin
               st_nxt  = wwc_pkg::WWC_ST_FAULT;
               flt_nxt = '0;
            end else if (ovf) begin
               devrst_nxt = 1'b1;
               to_nxt     = 1'b1;
            end else if (HALT_IN) begin
               st_nxt      = wwc_pkg::WWC_ST_SLEEP;
               pwr_down_nxt = 1'b1;
               to_nxt      = 1'b0;
               clear_cnt   = 1'b1;
               blocked_nxt = INT_REQ_IN;
            end else if (WATCHDOG_CLEAR_INSTRUCTION_IN) begin
               pwr_down_nxt = 1'b0;
               clear_cnt = 1'b1;
            end
         end
         wwc_pkg::WWC_ST_SLEEP: begin
            if (!key_ok) begin
               st_nxt  = wwc_pkg::WWC_ST_FAULT;
               flt_nxt = '0;
            end else if (ovf) begin
               st_nxt    = wwc_pkg::WWC_ST_RUN;
               wake_nxt  = 1'b1;
               cause_nxt = wwc_pkg::CAUSE_WDT;
               pcsp_nxt  = 1'b1;
               to_nxt    = 1'b1;
            end else if (|new_req) begin
               st_nxt    = wwc_pkg::WWC_ST_RUN;
               wake_nxt  = 1'b1;
               cause_nxt = wwc_pkg::CAUSE_INT;
               svc_nxt   = svc;
            end else if (|pin_fall) begin
               st_nxt    = wwc_pkg::WWC_ST_RUN;
               wake_nxt  = 1'b1;
               cause_nxt = wwc_pkg::CAUSE_PIN;
            end
         end
         wwc_pkg::WWC_ST_FAULT: begin
            // Delay runs to the end even if the key is repaired meanwhile
            if (flt_r == FLT_W'(KEY_FAULT_DELAY_CYC - 1)) begin
               st_nxt     = wwc_pkg::WWC_ST_RUN;
               devrst_nxt = 1'b1;
               key_flag_nxt  = 1'b1;
               wdog_ctrl_nxt = wwc_pkg::WDT_CTRL_POR;
               clear_cnt  = 1'b1;
            end else begin
               flt_nxt = flt_r + 1'b1;
            end
         end
         default: begin
            st_nxt = wwc_pkg::WWC_ST_RUN;
         end
      endcase

      // Counter runs in run and sleep while enabled
      if (clear_cnt || ovf) begin
         cnt_nxt = '0;
      end else if (enabled && tick && st_r != wwc_pkg::WWC_ST_FAULT) begin
         cnt_nxt = cnt_inc;
      end else begin
         cnt_nxt = cnt_r;
      end

      // Read data, valid only in the cycle after the strobe
      rdata_nxt = 8'h00;
      if (REG_RD_IN) begin
         case (REG_ADDR_IN)
            wwc_pkg::ADDR_WDT_CTRL:  rdata_nxt = wdog_ctrl_r;
            wwc_pkg::ADDR_RST_CAUSE: rdata_nxt = {7'h00, key_flag_r};
            wwc_pkg::ADDR_PORT_WAKE: rdata_nxt = pin_wake_en_r;
            wwc_pkg::ADDR_STATUS:    rdata_nxt = {5'h00, enabled, to_r, pwr_down_r};
            default:                 rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         st_r      <= wwc_pkg::WWC_ST_RUN;
         wdog_ctrl_r   <= wwc_pkg::WDT_CTRL_POR;
         pin_wake_en_r <= wwc_pkg::PORT_WAKE_POR;
         key_flag_r    <= 1'b0;
         pwr_down_r    <= 1'b0;
         to_r      <= 1'b0;
         cnt_r     <= 16'h0000;
         flt_r     <= '0;
         pa_prev_r <= '0;
         blocked_r <= '0;
         rdata_r   <= 8'h00;
         wake_r    <= 1'b0;
         cause_r   <= wwc_pkg::CAUSE_NONE;
         svc_r     <= 1'b0;
         devrst_r  <= 1'b0;
         pcsp_r    <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         wdog_ctrl_r   <= wdog_ctrl_nxt;
         pin_wake_en_r <= pin_wake_en_nxt;
         key_flag_r    <= key_flag_nxt;
         pwr_down_r    <= pwr_down_nxt;
         to_r      <= to_nxt;
         cnt_r     <= cnt_nxt;
         flt_r     <= flt_nxt;
         pa_prev_r <= PORT_A_IN;
         blocked_r <= blocked_nxt;
         rdata_r   <= rdata_nxt;
         wake_r    <= wake_nxt;
         cause_r   <= cause_nxt;
         svc_r     <= svc_nxt;
         devrst_r  <= devrst_nxt;
         pcsp_r    <= pcsp_nxt;
      end
   end

   assign REG_RDATA_OUT       = rdata_r;
   assign SLEEP_OUT           = (st_r == wwc_pkg::WWC_ST_SLEEP);
   assign WAKE_OUT            = wake_r;
   assign WAKE_CAUSE_OUT      = cause_r;
   assign WAKE_SERVICE_OUT    = svc_r;
   assign DEVICE_RESET_OUT    = devrst_r;
   assign PC_SP_RESET_OUT     = pcsp_r;
   assign POWER_DOWN_FLAG_OUT = pwr_down_r;
   assign TIMEOUT_FLAG_OUT    = to_r;
   assign WDT_ENABLED_OUT     = enabled;

   // Checks
   a_halt_enters_sleep: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_RUN && key_ok && !ovf && HALT_IN
      |=> SLEEP_OUT && POWER_DOWN_FLAG_OUT && !TIMEOUT_FLAG_OUT && cnt_r == 16'h0000)
      else $error("halt did not enter sleep with flags set");

   a_clear_drops_pdf: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_RUN && key_ok && !ovf && !HALT_IN && WATCHDOG_CLEAR_INSTRUCTION_IN
      |=> !POWER_DOWN_FLAG_OUT && cnt_r == 16'h0000)
      else $error("clear instruction left power-down flag or count");

   a_sleep_ovf_wake: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_SLEEP && key_ok && ovf
      |=> PC_SP_RESET_OUT && TIMEOUT_FLAG_OUT && !DEVICE_RESET_OUT
          && $stable(POWER_DOWN_FLAG_OUT) && WAKE_CAUSE_OUT == wwc_pkg::CAUSE_WDT)
      else $error("sleep overflow did not give a PC/SP reset wake");

   a_pin_wake: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_SLEEP && key_ok && !ovf && new_req == '0 && pin_fall != '0
      |=> WAKE_OUT && !WAKE_SERVICE_OUT && !SLEEP_OUT && WAKE_CAUSE_OUT == wwc_pkg::CAUSE_PIN)
      else $error("enabled pin falling edge did not wake");

   a_int_service: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_SLEEP && key_ok && !ovf && new_req != '0
      |=> WAKE_OUT && WAKE_SERVICE_OUT == $past(svc) && WAKE_CAUSE_OUT == wwc_pkg::CAUSE_INT)
      else $error("interrupt wake gave wrong service choice");

   a_old_req_blocked: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_RUN && key_ok && !ovf && HALT_IN
      ##1 (INT_REQ_IN == $past(INT_REQ_IN) && PORT_A_IN == pa_prev_r && !ovf && key_ok)
      |=> !WAKE_OUT)
      else $error("request pending at halt woke the device");

   a_limit_exact: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      ovf |-> cnt_r == wwc_limit(wdog_ctrl_r[wwc_pkg::SEL_MSB:wwc_pkg::SEL_LSB]) - 16'h0001
      ##1 cnt_r == 16'h0000)
      else $error("overflow not at selected limit");

   a_disabled_holds: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      key == wwc_pkg::KEY_DISABLE && !REG_WR_IN && !HALT_IN && !WATCHDOG_CLEAR_INSTRUCTION_IN
      |=> $stable(cnt_r) && !DEVICE_RESET_OUT && !PC_SP_RESET_OUT)
      else $error("disabled watchdog counted or reset");

   a_fault_end: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_FAULT && flt_r == FLT_W'(KEY_FAULT_DELAY_CYC - 1)
      |=> DEVICE_RESET_OUT && key_flag_r && wdog_ctrl_r == wwc_pkg::WDT_CTRL_POR
          && cnt_r == 16'h0000)
      else $error("key fault did not reset with flag and default control");

   a_run_timeout: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_RUN && key_ok && ovf
      |=> DEVICE_RESET_OUT && TIMEOUT_FLAG_OUT && !PC_SP_RESET_OUT ##1 !DEVICE_RESET_OUT)
      else $error("running timeout did not reset device");

   a_cause_reserved: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      REG_RD_IN && REG_ADDR_IN == wwc_pkg::ADDR_RST_CAUSE
      |=> REG_RDATA_OUT[7:1] == 7'h00 && REG_RDATA_OUT[0] == $past(key_flag_r))
      else $error("reset cause read shows reserved bits");

   // Further invariants: tick, power-on defaults, flags, sleep counting, wake pulse, stack full, reset kind and fault
   a_tick_period: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      tick |=> !tick)
      else $error("slow tick lasted more than one cycle");

   a_por_defaults: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $fell(SYS_RST_IN) |-> wdog_ctrl_r == wwc_pkg::WDT_CTRL_POR && !key_flag_r && !pwr_down_r)
      else $error("power-on control or flags wrong");

   a_key_flag_hold: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      key_flag_r && !(REG_WR_IN && REG_ADDR_IN == wwc_pkg::ADDR_RST_CAUSE
                      && !REG_WDATA_IN[wwc_pkg::KEY_FLAG_BIT])
      |=> key_flag_r)
      else $error("key fault flag dropped without software clear");

   a_key_flag_set: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      !key_flag_r && !(st_r == wwc_pkg::WWC_ST_FAULT && flt_r == FLT_W'(KEY_FAULT_DELAY_CYC - 1))
      |=> !key_flag_r)
      else $error("key fault flag set without fault reset");

   a_pdf_source: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $changed(pwr_down_r) |-> $past(HALT_IN) || $past(WATCHDOG_CLEAR_INSTRUCTION_IN))
      else $error("power-down flag moved without halt or clear");

   a_sleep_counts: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_SLEEP && key_ok && enabled && tick && !ovf
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("enabled watchdog stopped counting in sleep");

   a_wake_pulse: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      WAKE_OUT |-> !SLEEP_OUT ##1 !WAKE_OUT)
      else $error("wake pulse longer than one cycle or still asleep");

   a_stack_full_resume: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_SLEEP && key_ok && !ovf && new_req != '0 && STACK_FULL_IN
      |=> WAKE_OUT && !WAKE_SERVICE_OUT)
      else $error("interrupt serviced with a full stack");

   a_sleep_reset_only: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      PC_SP_RESET_OUT |-> WAKE_OUT && !DEVICE_RESET_OUT)
      else $error("sleep overflow gave a full device reset");

   a_fault_no_sleep: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      st_r == wwc_pkg::WWC_ST_FAULT |=> !SLEEP_OUT)
      else $error("halt accepted during key fault delay");
endmodule : wwc_watchdog_wake

/* tb/wwc_core_model.sv */
// Core model: turns bench requests into one-cycle halt and clear strobes.
// Assumes one-cycle request pulses on the block's clock.
`timescale 1ns/10ps
module wwc_core_model #(
   parameter int unsigned KEEP_CYC = 500
) (
   // Clock
   input  wire logic clk_in,
   // Requests from bench
   input  wire logic halt_req_in,
   input  wire logic clr_req_in,
   input  wire logic keepalive_in,
   // Strobes to block
   output logic      halt_out,
   output logic      clr_out
);
   // Two-state count, so it is defined from time zero
   int unsigned keep_cnt_r;
   int unsigned keep_cnt_nxt;

   always_comb begin
      keep_cnt_nxt = (keep_cnt_r + 1) % KEEP_CYC;
   end

   always_ff @(posedge clk_in) begin
      halt_out   <= halt_req_in;
      clr_out    <= clr_req_in | (keepalive_in && keep_cnt_r == 0);
      keep_cnt_r <= keep_cnt_nxt;
   end
endmodule : wwc_core_model

/* tb/wwc_watchdog_wake_tb.sv */
// Self-checking bench of the watchdog and wake-up block.
// Assumes shortened slow tick and key fault delay parameters.
`timescale 1ns/10ps
module wwc_watchdog_wake_tb;
   localparam int DIV = 4;
   localparam int DLY = 4;
   logic       clk, rst, wr, rd, halt_req, clr_req, keepalive, stack_full;
   logic [1:0] addr, cause;
   logic [7:0] wdata, port_a, int_req, int_en, rdata;
   logic       halt_s, clr_s, sleep, wake, svc, dev_rst, pcsp, pd_flag, to, en;
   int         errors, n_checks, n;

   wwc_watchdog_wake #(.PORT_A_WIDTH(8), .INT_COUNT(8), .SLOW_DIV_CYC(DIV),
      .KEY_FAULT_DELAY_CYC(DLY)) i_dut (
      .CLOCK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .HALT_IN(halt_s),
      .WATCHDOG_CLEAR_INSTRUCTION_IN(clr_s), .PORT_A_IN(port_a), .INT_REQ_IN(int_req), .INT_EN_IN(int_en),
      .STACK_FULL_IN(stack_full), .SLEEP_OUT(sleep), .WAKE_OUT(wake),
      .WAKE_CAUSE_OUT(cause), .WAKE_SERVICE_OUT(svc), .DEVICE_RESET_OUT(dev_rst),
      .PC_SP_RESET_OUT(pcsp), .POWER_DOWN_FLAG_OUT(pd_flag), .TIMEOUT_FLAG_OUT(to),
      .WDT_ENABLED_OUT(en));

   wwc_core_model i_core (.clk_in(clk), .halt_req_in(halt_req), .clr_req_in(clr_req),
      .keepalive_in(keepalive), .halt_out(halt_s), .clr_out(clr_s));

   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic complete_run();
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   function automatic logic ev(input int s);
      case (s)
         0: ev = wake;
         1: ev = dev_rst;
         default: ev = pcsp;
      endcase
   endfunction : ev

   // Bounded wait; running out ends the run as a mismatch
   task automatic wait_ev(input int s, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > lim) begin
            chk(8'h00, 8'h01);
            complete_run();
         end
      end while (ev(s) !== 1'h1);
   endtask : wait_ev

   task automatic no_ev(input int s, input int cyc);
      repeat (cyc) begin
         @(posedge clk);
         #1;
         chk({7'h00, ev(s)}, 8'h00);
      end
   endtask : no_ev

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
   endtask : wr_reg

   task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd   <= 1'h0;
      #1;
      chk(rdata, e);
   endtask : rd_chk

   task automatic do_halt();
      int k;
      k = 0;
      @(posedge clk);
      halt_req <= 1'h1;
      @(posedge clk);
      halt_req <= 1'h0;
      while (sleep !== 1'h1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk({6'h00, to, pd_flag}, 8'h01);
   endtask : do_halt

   task automatic do_clr();
      @(posedge clk);
      clr_req <= 1'h1;
      @(posedge clk);
      clr_req <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask : do_clr

   task automatic pin_wake(input logic [7:0] p, input logic [1:0] c);
      @(posedge clk);
      port_a <= p;
      wait_ev(0, 8, n);
      chk({5'h00, svc, cause}, {6'h00, c});
      @(posedge clk);
      port_a <= 8'hFF;
   endtask : pin_wake

   task automatic t_regs();
      rd_chk(wwc_pkg::ADDR_WDT_CTRL, 8'h53);
      rd_chk(wwc_pkg::ADDR_RST_CAUSE, 8'h00);
      rd_chk(wwc_pkg::ADDR_PORT_WAKE, 8'h00);
      rd_chk(wwc_pkg::ADDR_STATUS, 8'h04);
   endtask : t_regs

   task automatic t_pin();
      wr_reg(wwc_pkg::ADDR_PORT_WAKE, 8'h01);
      do_halt();
      @(posedge clk);
      port_a <= 8'hFD;
      no_ev(0, 20);
      pin_wake(8'hFC, 2'h1);
      do_clr();
      chk({7'h00, pd_flag}, 8'h00);
   endtask : t_pin

   task automatic t_int();
      logic [7:0] ens [3] = '{8'h00, 8'h02, 8'h02};
      logic       sfs [3] = '{1'h0, 1'h0, 1'h1};
      logic       exp [3] = '{1'h0, 1'h1, 1'h0};
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         int_req <= 8'h01;
         do_halt();
         no_ev(0, 20);
         @(posedge clk);
         int_en     <= ens[k];
         stack_full <= sfs[k];
         int_req    <= 8'h03;
         wait_ev(0, 8, n);
         chk({5'h00, svc, cause}, {5'h00, exp[k], 2'h2});
         @(posedge clk);
         int_req <= 8'h00;
      end
   endtask : t_int

   task automatic t_keepalive();
      wr_reg(wwc_pkg::ADDR_WDT_CTRL, 8'h50);
      do_clr();
      @(posedge clk);
      keepalive <= 1'h1;
      no_ev(1, 2000);
      @(posedge clk);
      keepalive <= 1'h0;
   endtask : t_keepalive

   task automatic t_run_ovf();
      int lim;
      for (int s = 0; s < 2; s++) begin
         lim = (256 << s) * DIV;
         wr_reg(wwc_pkg::ADDR_WDT_CTRL, 8'h50 | 8'(s));
         do_clr();
         wait_ev(1, lim + DIV, n);
         chk({7'h00, (n >= lim - 2 * DIV)}, 8'h01);
         chk({6'h00, to, sleep}, 8'h02);
      end
   endtask : t_run_ovf

   task automatic t_sleep_ovf();
      wr_reg(wwc_pkg::ADDR_WDT_CTRL, 8'h50);
      do_halt();
      wait_ev(2, 256 * DIV + DIV, n);
      chk({7'h00, (n >= 256 * DIV - 2 * DIV)}, 8'h01);
      chk({3'h0, dev_rst, to, pd_flag, cause}, 8'h0F);
   endtask : t_sleep_ovf

   task automatic t_disabled();
      wr_reg(wwc_pkg::ADDR_WDT_CTRL, 8'hA8);
      do_clr();
      chk({7'h00, en}, 8'h00);
      no_ev(1, 1200);
      do_halt();
      no_ev(2, 1200);
      pin_wake(8'hFE, 2'h1);
      wr_reg(wwc_pkg::ADDR_WDT_CTRL, 8'h50);
      #1;
      chk({7'h00, en}, 8'h01);
   endtask : t_disabled

   task automatic t_keyfault();
      wr_reg(wwc_pkg::ADDR_WDT_CTRL, 8'h00);
      wait_ev(1, DLY + 2, n);
      chk({7'h00, (n >= DLY)}, 8'h01);
      rd_chk(wwc_pkg::ADDR_RST_CAUSE, 8'h01);
      rd_chk(wwc_pkg::ADDR_WDT_CTRL, 8'h53);
      wr_reg(wwc_pkg::ADDR_RST_CAUSE, 8'hFF);
      rd_chk(wwc_pkg::ADDR_RST_CAUSE, 8'h01);
      wr_reg(wwc_pkg::ADDR_RST_CAUSE, 8'h00);
      rd_chk(wwc_pkg::ADDR_RST_CAUSE, 8'h00);
   endtask : t_keyfault

   initial begin
      errors = 0;
      n_checks = 0;
      rst = 1'h1;
      {wr, rd, halt_req, clr_req, keepalive, stack_full} = 6'h00;
      addr = 2'h0;
      wdata = 8'h00;
      port_a = 8'hFF;
      int_req = 8'h00;
      int_en = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_regs();
      t_pin();
      t_int();
      t_keepalive();
      t_run_ovf();
      t_sleep_ovf();
      t_disabled();
      t_keyfault();
      complete_run();
   end
endmodule : wwc_watchdog_wake_tb
